// ==== logic/acd_pkg.sv ====
// acd_pkg: constants and types shared by the addressing mode decoder
// assumes: imported by scope only, by the decoder top, acd_classify and the bench
package acd_pkg;

  // ----------------------------------------------------------------
  // prefix bytes and opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] Y_SELECT_PREFIX = 8'h90;
  localparam logic [7:0] Y_INDIRECT_PREFIX = 8'h91;
  localparam logic [7:0] INDIRECT_SELECT_PREFIX = 8'h92;
  // opcode high nibble: base addressing form
  localparam logic [3:0] BF_INH = 4'h0;
  localparam logic [3:0] BF_IMM = 4'h1;
  localparam logic [3:0] BF_DIR_S = 4'h2;
  localparam logic [3:0] BF_DIR_L = 4'h3;
  localparam logic [3:0] BF_IDX_0 = 4'h4;
  localparam logic [3:0] BF_IDX_S = 4'h5;
  localparam logic [3:0] BF_IDX_L = 4'h6;
  localparam logic [3:0] BF_REL = 4'h7;
  localparam logic [3:0] BF_BIT = 4'h8;
  localparam logic [3:0] BF_BREL = 4'hA;
  // opcode low nibble: operations at or above this are short-only
  localparam logic [3:0] OP_SHORT_ONLY_MIN = 4'hA;
  // inherent operations with side effects
  localparam logic [3:0] INH_MASK = 4'h1;
  localparam logic [3:0] INH_UNMASK = 4'h2;
  localparam logic [3:0] INH_SET_CARRY = 4'h3;
  localparam logic [3:0] INH_CLR_CARRY = 4'h4;
  localparam logic [3:0] INH_WAIT = 4'h5;
  // interrupt mask levels
  localparam logic [1:0] IMASK_HIGHEST = 2'h3;
  localparam logic [1:0] IMASK_LOWEST = 2'h0;
  localparam logic [1:0] IMASK_RESET = 2'h3;
  // top of the extended page-zero range
  localparam logic [15:0] SHORT_IDX_TOP = 16'h01FE;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PFX_NONE = 2'h0, PFX_Y = 2'h1, PFX_IND = 2'h2,
                            PFX_YIND = 2'h3} acd_pfx_t;
  typedef enum logic [4:0] {
    M_INH = 5'h00, M_IMM = 5'h01, M_DIR_S = 5'h02, M_DIR_L = 5'h03,
    M_IDX_0 = 5'h04, M_IDX_S = 5'h05, M_IDX_L = 5'h06, M_IND_S = 5'h07,
    M_IND_L = 5'h08, M_INDX_S = 5'h09, M_INDX_L = 5'h0A, M_REL_D = 5'h0B,
    M_REL_I = 5'h0C, M_BIT_D = 5'h0D, M_BIT_I = 5'h0E, M_BREL_D = 5'h0F,
    M_BREL_I = 5'h10} acd_mode_t;
  typedef enum logic [3:0] {ST_OPC = 4'h1, ST_OPND = 4'h2, ST_PTR = 4'h4,
                            ST_CALC = 4'h8} acd_state_t;
  typedef struct packed {
    acd_mode_t mode;
    logic use_y;
    logic [1:0] opnd_bytes;
    logic [1:0] ptr_bytes;
    logic disp_in_stream;
    logic indexed;
    logic illegal;
    logic [3:0] op;
  } acd_dec_t;
  typedef struct packed {
    acd_mode_t mode;
    logic [3:0] op;
    logic use_y;
    logic [1:0] opnd_bytes;
    logic [2:0] instr_len;
    logic [15:0] ea;
    logic [15:0] target;
  } acd_res_t;
  typedef struct packed {
    logic mask_set;
    logic mask_clr;
    logic carry_set;
    logic carry_clr;
    logic wait_req;
  } acd_cc_t;

  // long forms, which the short-only operations may not use
  function automatic logic is_long(input acd_mode_t m);
    is_long = (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L) || (m == M_INDX_L);
  endfunction : is_long

endpackage : acd_pkg

// ==== logic/acd_classify.sv ====
// acd_classify: opcode plus prefix to addressing form, byte counts, legality
// assumes: the prefix seen ahead of the opcode is given, PFX_NONE if none
`timescale 1ns/100ps
module acd_classify
(
  // opcode and prefix
  input logic [7:0] opcode,
  input acd_pkg::acd_pfx_t pfx,
  // decoded form
  output acd_pkg::acd_dec_t dec
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic acd_pkg::acd_dec_t classify(input logic [7:0] opc,
                                                 input acd_pkg::acd_pfx_t p);
    acd_pkg::acd_dec_t d;
    logic ind;
    logic ind_x;
    logic ysel;
    d = '0;
    ind = (p == acd_pkg::PFX_IND);
    ind_x = ind || (p == acd_pkg::PFX_YIND);
    ysel = (p == acd_pkg::PFX_Y);
    d.op = opc[3:0];
    d.mode = acd_pkg::M_INH;
    case (opc[7:4])
      acd_pkg::BF_INH:
        d.use_y = ysel;
      acd_pkg::BF_IMM:
      begin
        d.mode = acd_pkg::M_IMM;
        d.use_y = ysel;
        d.opnd_bytes = 2'h1;
        d.illegal = (opc[3:0] >= acd_pkg::OP_SHORT_ONLY_MIN);
      end
      acd_pkg::BF_DIR_S:
      begin
        d.mode = ind ? acd_pkg::M_IND_S : acd_pkg::M_DIR_S;
        d.use_y = ysel;
        d.opnd_bytes = 2'h1;
        d.ptr_bytes = {1'b0, ind};
      end
      acd_pkg::BF_DIR_L:
      begin
        d.mode = ind ? acd_pkg::M_IND_L : acd_pkg::M_DIR_L;
        d.use_y = ysel;
        d.opnd_bytes = ind ? 2'h1 : 2'h2;
        d.ptr_bytes = ind ? 2'h2 : 2'h0;
      end
      acd_pkg::BF_IDX_0:
      begin
        d.mode = acd_pkg::M_IDX_0;
        d.use_y = ysel;
        d.indexed = 1'b1;
      end
      acd_pkg::BF_IDX_S:
      begin
        d.mode = ind_x ? acd_pkg::M_INDX_S : acd_pkg::M_IDX_S;
        d.use_y = ysel || (p == acd_pkg::PFX_YIND);
        d.indexed = 1'b1;
        d.opnd_bytes = 2'h1;
        d.ptr_bytes = {1'b0, ind_x};
      end
      acd_pkg::BF_IDX_L:
      begin
        d.mode = ind_x ? acd_pkg::M_INDX_L : acd_pkg::M_IDX_L;
        d.use_y = ysel || (p == acd_pkg::PFX_YIND);
        d.indexed = 1'b1;
        d.opnd_bytes = ind_x ? 2'h1 : 2'h2;
        d.ptr_bytes = ind_x ? 2'h2 : 2'h0;
      end
      acd_pkg::BF_REL:
      begin
        d.mode = ind ? acd_pkg::M_REL_I : acd_pkg::M_REL_D;
        d.opnd_bytes = 2'h1;
        d.ptr_bytes = {1'b0, ind};
        d.disp_in_stream = !ind;
      end
      acd_pkg::BF_BIT:
      begin
        d.mode = ind ? acd_pkg::M_BIT_I : acd_pkg::M_BIT_D;
        d.opnd_bytes = 2'h1;
        d.ptr_bytes = {1'b0, ind};
      end
      acd_pkg::BF_BREL:
      begin
        d.mode = ind ? acd_pkg::M_BREL_I : acd_pkg::M_BREL_D;
        d.opnd_bytes = 2'h2;
        d.ptr_bytes = {1'b0, ind};
        d.disp_in_stream = 1'b1;
      end
      default:
        d.illegal = 1'b1;
    endcase
    // short-only operations have no long form
    if (acd_pkg::is_long(d.mode) && (opc[3:0] >= acd_pkg::OP_SHORT_ONLY_MIN))
      d.illegal = 1'b1;
    classify = d;
  endfunction : classify

  assign dec = classify(opcode, pfx);

endmodule : acd_classify

// ==== logic/acd_ea_calc.sv ====
// acd_ea_calc: operand address and relative jump target arithmetic
// assumes: all inputs are stable registers of the decoder's clock domain
`timescale 1ns/100ps
module acd_ea_calc
(
  // operand sources
  input logic indexed,
  input logic [7:0] idx,
  input logic [15:0] base,
  input logic [15:0] pc,
  input logic [7:0] disp,
  // results
  output logic [15:0] ea,
  output logic [15:0] target
);

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // index is widened, never truncated, so short forms reach 01FE
  function automatic logic [15:0] zext_sum(input logic [15:0] a, input logic [7:0] b);
    zext_sum = a + {8'h00, b};
  endfunction : zext_sum

  // index plus offset or pointer, unsigned at address width
  assign ea = indexed ? zext_sum(base, idx) : base;
  // displacement sign-extended, pc already past the instruction
  assign target = pc + {{8{disp[7]}}, disp};

endmodule : acd_ea_calc

// ==== logic/acd_decoder.sv ====
// acd_decoder: addressing mode decoder and effective address sequencer
// assumes: fetch bytes, index registers and pc come from core logic on clk_sys;
// pointer bytes are read through a simple request/valid memory port
//
// Function
// - inherent forms are one opcode byte, no operand bytes follow
// - immediate forms carry one literal byte, only for load/compare/logic/arith
// - short direct takes one address byte, reaching page zero only
// - long direct takes a two-byte address reaching the full space
// - indexed address is unsigned sum of X or Y and the offset
// - no-offset indexed uses the index alone, no byte after opcode
// - no-offset indexed costs no byte with X, one prefix byte with Y
// - short indexed adds one offset byte untruncated, reaching 01FE
// - long indexed adds a two-byte offset reaching the full space
// - short indirect reads a one-byte pointer from page zero
// - long indirect forms read a two-byte pointer from page zero
// - indirect indexed adds X or Y to the pointer read from memory
// - short indirect indexed adds index to byte pointer, reaching 01FE
// - relative target is pc of next instruction plus signed displacement
// - read-modify-write operations accept short forms only
// - short-only group uses direct, indexed, indirect, indirect indexed short
// - load, compare, logic and arithmetic accept short and long forms
// - mask ops set mask highest or lowest; carry ops set or clear
// - the Y prefix swaps X for Y in X-based forms
// - the indirect prefix turns direct and offset X-indexed forms indirect
`timescale 1ns/100ps
module acd_decoder
(
  // clock and reset
  input logic clk_sys,
  input logic reset_n,
  // instruction byte stream
  input logic fetch_valid,
  input logic [7:0] fetch_byte,
  output logic fetch_ready,
  // pointer reads from memory
  output logic rd_req,
  output logic [15:0] rd_addr,
  input logic [7:0] rd_data,
  input logic rd_valid,
  // core state
  input logic [7:0] x_index,
  input logic [7:0] y_index,
  input logic [15:0] pc_next,
  // decoded results
  output logic done,
  output logic illegal,
  output acd_pkg::acd_res_t res,
  output acd_pkg::acd_cc_t cc,
  output logic [1:0] imask_level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  acd_pkg::acd_state_t state_reg, state_next;
  acd_pkg::acd_pfx_t pfx_reg, pfx_next;
  acd_pkg::acd_dec_t dec_reg, dec_next;
  logic [1:0] left_reg, left_next;
  logic [1:0] ptr_left_reg, ptr_left_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] disp_reg, disp_next;
  logic fetch_ready_reg, fetch_ready_next;
  logic rd_req_reg, rd_req_next;
  logic [15:0] rd_addr_reg, rd_addr_next;
  logic done_reg, done_next;
  logic illegal_reg, illegal_next;
  acd_pkg::acd_res_t res_reg, res_next;
  acd_pkg::acd_cc_t cc_reg, cc_next;
  logic [1:0] imask_reg, imask_next;
  acd_pkg::acd_dec_t dec_now;
  logic [15:0] ea_now;
  logic [15:0] tgt_now;
  logic [7:0] idx_sel;
  logic take;

  // ----------------------------------------------------------------
  // prefix helpers
  // ----------------------------------------------------------------
  function automatic logic is_prefix(input logic [7:0] b);
    is_prefix = (b == acd_pkg::Y_SELECT_PREFIX) || (b == acd_pkg::Y_INDIRECT_PREFIX) ||
                (b == acd_pkg::INDIRECT_SELECT_PREFIX);
  endfunction : is_prefix

  function automatic acd_pkg::acd_pfx_t to_pfx(input logic [7:0] b);
    case (b)
      acd_pkg::Y_SELECT_PREFIX: to_pfx = acd_pkg::PFX_Y;
      acd_pkg::Y_INDIRECT_PREFIX: to_pfx = acd_pkg::PFX_YIND;
      acd_pkg::INDIRECT_SELECT_PREFIX: to_pfx = acd_pkg::PFX_IND;
      default: to_pfx = acd_pkg::PFX_NONE;
    endcase
  endfunction : to_pfx

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // the opcode is classified as it arrives, against the stored prefix
  acd_classify u_classify
  (
    .opcode(fetch_byte),
    .pfx(pfx_reg),
    .dec(dec_now)
  );

  // index chosen by the decoded form, sampled only in the calc cycle
  assign idx_sel = dec_reg.use_y ? y_index : x_index;

  acd_ea_calc u_ea_calc
  (
    .indexed(dec_reg.indexed),
    .idx(idx_sel),
    .base(addr_reg),
    .pc(pc_next),
    .disp(disp_reg),
    .ea(ea_now),
    .target(tgt_now)
  );

  assign take = fetch_valid && fetch_ready_reg;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // next values of the whole decode sequence
  always_comb
  begin
    state_next = state_reg;
    pfx_next = pfx_reg;
    dec_next = dec_reg;
    left_next = left_reg;
    ptr_left_next = ptr_left_reg;
    addr_next = addr_reg;
    disp_next = disp_reg;
    rd_req_next = rd_req_reg;
    rd_addr_next = rd_addr_reg;
    res_next = res_reg;
    imask_next = imask_reg;
    done_next = 1'b0;
    illegal_next = 1'b0;
    cc_next = '0;
    unique case (state_reg)
      acd_pkg::ST_OPC:
      begin
        if (take)
        begin
          if (is_prefix(fetch_byte) && (pfx_reg == acd_pkg::PFX_NONE))
            pfx_next = to_pfx(fetch_byte);
          else if (dec_now.illegal || is_prefix(fetch_byte))
          begin
            // undefined code or second prefix: flagged, sequence dropped
            illegal_next = 1'b1;
            pfx_next = acd_pkg::PFX_NONE;
          end
          else
          begin
            dec_next = dec_now;
            left_next = dec_now.opnd_bytes;
            ptr_left_next = dec_now.ptr_bytes;
            addr_next = '0;
            disp_next = '0;
            // inherent and no-offset forms go straight to calc
            if (dec_now.opnd_bytes == 2'h0)
              state_next = acd_pkg::ST_CALC;
            else
              state_next = acd_pkg::ST_OPND;
          end
        end
      end
      acd_pkg::ST_OPND:
      begin
        if (take)
        begin
          left_next = left_reg - 2'h1;
          // a displacement is always the last byte of its instruction
          if ((left_reg == 2'h1) && dec_reg.disp_in_stream)
            disp_next = fetch_byte;
          else
            addr_next = {addr_reg[7:0], fetch_byte};
          if (left_reg == 2'h1)
          begin
            if (dec_reg.ptr_bytes != 2'h0)
            begin
              // pointers live in page zero; high byte read first
              state_next = acd_pkg::ST_PTR;
              rd_req_next = 1'b1;
              rd_addr_next = {8'h00, addr_next[7:0]};
              addr_next = '0;
            end
            else
              state_next = acd_pkg::ST_CALC;
          end
        end
      end
      acd_pkg::ST_PTR:
      begin
        if (rd_valid)
        begin
          ptr_left_next = ptr_left_reg - 2'h1;
          if (dec_reg.mode == acd_pkg::M_REL_I)
            disp_next = rd_data;
          else
            addr_next = {addr_reg[7:0], rd_data};
          if (ptr_left_reg == 2'h1)
          begin
            rd_req_next = 1'b0;
            state_next = acd_pkg::ST_CALC;
          end
          else
            rd_addr_next = rd_addr_reg + 16'h0001;
        end
      end
      acd_pkg::ST_CALC:
      begin
        res_next.mode = dec_reg.mode;
        res_next.op = dec_reg.op;
        res_next.use_y = dec_reg.use_y;
        res_next.opnd_bytes = dec_reg.opnd_bytes;
        res_next.instr_len = {2'b00, pfx_reg != acd_pkg::PFX_NONE} + 3'h1 +
                             {1'b0, dec_reg.opnd_bytes};
        res_next.ea = ea_now;
        res_next.target = tgt_now;
        done_next = 1'b1;
        if (dec_reg.mode == acd_pkg::M_INH)
        begin
          case (dec_reg.op)
            acd_pkg::INH_MASK:
            begin
              cc_next.mask_set = 1'b1;
              imask_next = acd_pkg::IMASK_HIGHEST;
            end
            acd_pkg::INH_UNMASK:
            begin
              cc_next.mask_clr = 1'b1;
              imask_next = acd_pkg::IMASK_LOWEST;
            end
            acd_pkg::INH_SET_CARRY: cc_next.carry_set = 1'b1;
            acd_pkg::INH_CLR_CARRY: cc_next.carry_clr = 1'b1;
            acd_pkg::INH_WAIT: cc_next.wait_req = 1'b1;
            default: cc_next = '0;
          endcase
        end
        pfx_next = acd_pkg::PFX_NONE;
        state_next = acd_pkg::ST_OPC;
      end
    endcase
    // the stream is held off while pointers are read and the result formed
    fetch_ready_next = (state_next == acd_pkg::ST_OPC) || (state_next == acd_pkg::ST_OPND);
  end

  // registers only
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg <= acd_pkg::ST_OPC;
      pfx_reg <= acd_pkg::PFX_NONE;
      dec_reg <= '0;
      left_reg <= 2'h0;
      ptr_left_reg <= 2'h0;
      addr_reg <= 16'h0000;
      disp_reg <= 8'h00;
      fetch_ready_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      rd_addr_reg <= 16'h0000;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      res_reg <= '0;
      cc_reg <= '0;
      imask_reg <= acd_pkg::IMASK_RESET;
    end
    else
    begin
      state_reg <= state_next;
      pfx_reg <= pfx_next;
      dec_reg <= dec_next;
      left_reg <= left_next;
      ptr_left_reg <= ptr_left_next;
      addr_reg <= addr_next;
      disp_reg <= disp_next;
      fetch_ready_reg <= fetch_ready_next;
      rd_req_reg <= rd_req_next;
      rd_addr_reg <= rd_addr_next;
      done_reg <= done_next;
      illegal_reg <= illegal_next;
      res_reg <= res_next;
      cc_reg <= cc_next;
      imask_reg <= imask_next;
    end
  end

  assign fetch_ready = fetch_ready_reg;
  assign rd_req = rd_req_reg;
  assign rd_addr = rd_addr_reg;
  assign done = done_reg;
  assign illegal = illegal_reg;
  assign res = res_reg;
  assign cc = cc_reg;
  assign imask_level = imask_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence last_ptr_s;
    (state_reg == acd_pkg::ST_PTR) && rd_valid && (ptr_left_reg == 2'h1);
  endsequence
  sequence finish_s;
    (state_reg == acd_pkg::ST_CALC) && !fetch_ready_reg ##1 done_reg;
  endsequence
  sequence word_ptr_s;
    (state_reg == acd_pkg::ST_PTR) && rd_valid && (ptr_left_reg == 2'h2);
  endsequence

  // a prefix still stands in the calc cycle, so the past value tells its byte apart
  inh_len_a: assert property (
    done_reg && (res_reg.mode == acd_pkg::M_INH) |->
      (res_reg.opnd_bytes == 2'h0) &&
      (res_reg.instr_len == (($past(pfx_reg) == acd_pkg::PFX_NONE) ? 3'h1 : 3'h2)))
    else $error("inherent form reported operand bytes");
  imm_only_a: assert property (
    (state_reg == acd_pkg::ST_OPC) && take && (fetch_byte[7:4] == acd_pkg::BF_IMM) &&
      (fetch_byte[3:0] >= acd_pkg::OP_SHORT_ONLY_MIN) |=> illegal_reg && !done_reg)
    else $error("immediate form accepted for a short-only operation");
  dir_page_a: assert property (
    done_reg && (res_reg.mode == acd_pkg::M_DIR_S) |-> (res_reg.ea[15:8] == 8'h00))
    else $error("short direct address left page zero");
  idx0_page_a: assert property (
    done_reg && (res_reg.mode == acd_pkg::M_IDX_0) |->
      (res_reg.ea[15:8] == 8'h00) && (!res_reg.use_y || (res_reg.instr_len == 3'h2)) &&
      (res_reg.instr_len == (($past(pfx_reg) == acd_pkg::PFX_NONE) ? 3'h1 : 3'h2)))
    else $error("no-offset indexed address or length wrong");
  short_idx_a: assert property (
    done_reg && ((res_reg.mode == acd_pkg::M_IDX_S) || (res_reg.mode == acd_pkg::M_INDX_S))
      |-> (res_reg.ea <= acd_pkg::SHORT_IDX_TOP))
    else $error("short indexed address beyond extended page zero");
  rel_tgt_a: assert property (
    done_reg && (res_reg.mode == acd_pkg::M_REL_D) |->
      (res_reg.target == $past(pc_next) + {{8{$past(disp_reg[7])}}, $past(disp_reg)}))
    else $error("relative target not pc plus signed displacement");
  ptr_done_a: assert property (
    last_ptr_s |=> finish_s)
    else $error("result not formed right after the last pointer byte");
  ptr_step_a: assert property (
    word_ptr_s |=> rd_req_reg && (rd_addr_reg == $past(rd_addr_reg) + 16'h0001))
    else $error("second pointer byte not read from the next address");
  short_only_a: assert property (
    done_reg |-> !(acd_pkg::is_long(res_reg.mode) &&
      (res_reg.op >= acd_pkg::OP_SHORT_ONLY_MIN)))
    else $error("short-only operation completed in a long form");
  imask_a: assert property (
    done_reg && (res_reg.mode == acd_pkg::M_INH) && (res_reg.op == acd_pkg::INH_MASK)
      |-> cc_reg.mask_set && (imask_reg == acd_pkg::IMASK_HIGHEST))
    else $error("mask instruction did not raise the mask level");
  fetch_hold_a: assert property (
    (state_reg == acd_pkg::ST_PTR) |-> !fetch_ready_reg)
    else $error("stream accepted while pointer bytes were read");

endmodule : acd_decoder

// ==== tb/acd_decoder_bench.sv ====
// acd_decoder_bench: self-checking bench for the addressing mode decoder
// assumes: acd_pkg and the decoder files are compiled ahead of this file
`timescale 1ns/100ps
module acd_decoder_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic fetch_valid = 1'b0;
  logic [7:0] fetch_byte = 8'h00;
  logic fetch_ready;
  logic rd_req;
  logic [15:0] rd_addr;
  logic [7:0] rd_data = 8'h00;
  logic rd_valid = 1'b0;
  logic [7:0] x_index = 8'hFF;
  logic [7:0] y_index = 8'h3C;
  logic [15:0] pc_next = 16'h1000;
  logic done;
  logic illegal;
  acd_pkg::acd_res_t res;
  acd_pkg::acd_cc_t cc;
  logic [1:0] imask_level;
  logic [4:0] cc_seen;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int lat;

  acd_decoder acd_decoder_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .x_index(x_index), .y_index(y_index), .pc_next(pc_next), .done(done),
    .illegal(illegal), .res(res), .cc(cc), .imask_level(imask_level));

  // 125 MHz clock
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  // pointer memory content: address-dependent so a wrong address shows
  function automatic logic [7:0] mem(input logic [15:0] a);
    mem = a[7:0] ^ 8'hA5 ^ {7'h00, a[8]};
  endfunction : mem

  // memory answers a cycle late; data is scrambled outside a reply
  always @(posedge clk_sys)
  begin
    rd_valid <= rd_req && !rd_valid;
    rd_data <= (rd_req && !rd_valid) ? mem(rd_addr) : ~rd_data;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one byte per taken edge, most significant first, then release
  task automatic issue(input logic [31:0] w, input int n);
    int k;
    for (int i = n - 1; i >= 0; i--)
    begin
      fetch_valid <= 1'b1;
      fetch_byte <= w[8*i +: 8];
      k = 0;
      @(negedge clk_sys);
      while (fetch_ready !== 1'b1 && k < 50)
      begin
        @(negedge clk_sys);
        k++;
      end
      @(posedge clk_sys);
    end
    fetch_valid <= 1'b0;
  endtask : issue

  // bounded wait for done or illegal; lat counts cycles after last byte
  task automatic finish_op(input logic exp_ill);
    lat = 0;
    do
    begin
      @(negedge clk_sys);
      lat++;
    end
    while (done !== 1'b1 && illegal !== 1'b1 && lat < 50);
    cc_seen = cc;
    chk(16'(illegal), 16'(exp_ill));
    chk(16'(fetch_ready), 16'h0001);
    chk(16'(rd_req), 16'h0000);
    @(posedge clk_sys);
  endtask : finish_op

  task automatic chk_res(input logic [2:0] len, input logic [1:0] nb);
    finish_op(1'b0);
    chk(16'(res.instr_len), 16'(len));
    chk(16'(res.opnd_bytes), 16'(nb));
  endtask : chk_res

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_inherent();
    for (int op = 1; op <= 5; op++)
    begin
      issue(32'(op), 1);
      chk_res(3'h1, 2'h0);
      chk(16'(lat), 16'h0002);
      chk(16'(cc_seen), 16'(5'h10 >> (op - 1)));
      if (op < 3)
        chk(16'(imask_level), (op == 1) ? 16'h0003 : 16'h0000);
    end
  endtask : t_inherent

  task automatic t_direct();
    issue(32'h1055, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h0055);
    issue(32'h20FE, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h00FE);
    issue(32'h381234, 3);
    chk_res(3'h3, 2'h2);
    chk(res.ea, 16'h1234);
  endtask : t_direct

  // x is FF, y is 3C: the short offset sum with x carries past page zero
  task automatic t_indexed();
    issue(32'h40, 1);
    chk_res(3'h1, 2'h0);
    chk(res.ea, 16'h00FF);
    issue(32'h9040, 2);
    chk_res(3'h2, 2'h0);
    chk(res.ea, 16'h003C);
    chk(16'(res.use_y), 16'h0001);
    issue(32'h50FF, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h01FE);
    issue(32'h601234, 3);
    chk_res(3'h3, 2'h2);
    chk(res.ea, 16'h1333);
  endtask : t_indexed

  // word pointer at FF takes its second byte from 0100
  task automatic t_indirect();
    issue(32'h922080, 3);
    chk_res(3'h3, 2'h1);
    chk(res.ea, 16'h0025);
    issue(32'h9230FF, 3);
    chk_res(3'h3, 2'h1);
    chk(res.ea, 16'h5AA4);
    issue(32'h925080, 3);
    chk_res(3'h3, 2'h1);
    chk(res.ea, 16'h0124);
    issue(32'h915080, 3);
    chk_res(3'h3, 2'h1);
    chk(res.ea, 16'h0061);
    issue(32'h926010, 3);
    chk_res(3'h3, 2'h1);
    chk(res.ea, 16'hB6B3);
  endtask : t_indirect

  task automatic t_relative();
    issue(32'h7080, 2);
    chk_res(3'h2, 2'h1);
    chk(res.target, 16'h0F80);
    issue(32'h707F, 2);
    chk_res(3'h2, 2'h1);
    chk(res.target, 16'h107F);
    issue(32'h927080, 3);
    chk_res(3'h3, 2'h1);
    chk(res.target, 16'h1025);
  endtask : t_relative

  // bit form direct, bit-test-relative form direct and through a pointer
  task automatic t_bit();
    issue(32'h8710, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h0010);
    issue(32'hA310F0, 3);
    chk_res(3'h3, 2'h2);
    chk(res.target, 16'h0FF0);
    issue(32'h92A38005, 4);
    chk_res(3'h4, 2'h2);
    chk(res.ea, 16'h0025);
    chk(res.target, 16'h1005);
    chk(16'(res.mode), 16'(acd_pkg::M_BREL_I));
  endtask : t_bit

  // long or immediate forms of short-only ops are refused, short ones taken
  task automatic t_short_only();
    logic [15:0] bad_ops [5] = '{16'h001A, 16'h003A, 16'h006A, 16'h923A, 16'h9090};
    foreach (bad_ops[i])
    begin
      issue(32'(bad_ops[i]), (bad_ops[i][15:8] != 8'h00) ? 2 : 1);
      finish_op(1'b1);
      chk(16'(lat), 16'h0001);
    end
    issue(32'h2A40, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h0040);
    issue(32'h5A10, 2);
    chk_res(3'h2, 2'h1);
    chk(res.ea, 16'h010F);
  endtask : t_short_only

  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk(16'(imask_level), 16'h0003);
    t_inherent();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_bit();
    t_short_only();
    tally_and_finish();
  end
endmodule : acd_decoder_bench
